//--- logic/prs_pkg.sv
/*
 prs_pkg: constants and carrier types for the phy receive status block.
 assumes a 100 mhz ref_clk and a receive clock that is far slower than it.
*/
package prs_pkg;

   // clock and timing
   localparam int CLK_MHZ = 100;
   localparam int HB_PULSE_NS = 1000;
   localparam int HB_PULSE_CYCLES = (HB_PULSE_NS * CLK_MHZ) / 1000;
   localparam int HB_CNT_W = 8;
   localparam int SYNC_STAGES = 2;

   // receive nibble layout
   localparam int NIB_W = 4;
   localparam logic [3:0] NIB_RESET = 4'h0;

   ////////////////////////////////////////////////////////////////////////////

   // one nibble offered by the decoder
   typedef struct packed {
      logic valid;
      logic err;
      logic [NIB_W-1:0] data;
   } prs_nib_type;

   // operating mode of the link
   typedef struct packed {
      logic full_duplex;
      logic speed_100;
      logic heartbeat_en;
   } prs_mode_type;

   // mii receive outputs toward the mac
   typedef struct packed {
      logic rx_dv;
      logic rx_er;
      logic [NIB_W-1:0] rxd;
   } prs_mii_rx_type;

   typedef enum logic [0:0] {
      HB_IDLE,
      HB_PULSE
   } prs_hb_state_type;

endpackage : prs_pkg

//--- logic/prs_sync.sv
/*
 prs_sync: two flip-flop synchroniser for a bundle of independent levels.
 assumes each bit is a slow level; multi-bit words are not made coherent.
*/
module prs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   import prs_pkg::*;

   logic [WIDTH-1:0] meta_q;

   // first stage read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : prs_sync

//--- logic/prs_mii_status.sv
/*
 prs_mii_status: phy side mii carrier sense, collision, heartbeat, receive
 nibble launch and open-drain management data pin.
 assumes activity, mode and nibble inputs come from logic on ref_clk; the
 receive clock, management clock and management data pins are asynchronous.
*/
//
// Operation
// - half duplex: carrier sense follows receive or transmit activity.
// - full duplex: carrier sense follows receive activity only.
// - half duplex: collision high while transmit and receive overlap.
// - 10 Mb/s half duplex heartbeat: collision pulse of about 1 us.
// - received nibbles delivered synchronous to 25 or 2.5 MHz receive clock.
// - each nibble changes on the receive clock falling edge.
// - data valid high with a valid nibble, changed on falling edge.
// - 100 Mb/s: receive error high on invalid symbol inside a packet.
// - management data is open drain; either side only pulls low.
module prs_mii_status (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire prs_pkg::prs_mode_type mode,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire prs_pkg::prs_nib_type rx_nib,
   output logic rx_nib_take,
   input wire logic rx_clk,
   output logic crs,
   output logic col,
   output prs_pkg::prs_mii_rx_type mii_rx,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic mgmt_pull_low,
   output logic mgmt_mdc,
   output logic mgmt_mdio
);
   import prs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [2:0] pin_sync;
   logic rx_clk_s;
   logic rx_clk_prev_q;
   logic rx_clk_fall;

   prs_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .d({rx_clk, mdc, mdio_i}),
      .q(pin_sync)
   );

   assign rx_clk_s = pin_sync[2];
   assign mgmt_mdc = pin_sync[1];
   assign mgmt_mdio = pin_sync[0];

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_clk_prev_q <= 1'b0;
      end else begin
         rx_clk_prev_q <= rx_clk_s;
      end
   end

   // falling edge of receive clock
   assign rx_clk_fall = rx_clk_prev_q & ~rx_clk_s;

   ////////////////////////////////////////////////////////////////////////////
   // carrier sense and collision

   logic half_dup;
   logic crs_d;
   logic crs_q;
   logic col_d;
   logic col_q;
   logic hb_on;

   assign half_dup = ~mode.full_duplex;

   always_comb begin
      if (half_dup) begin
         crs_d = rx_active | tx_active;
      end else begin
         crs_d = rx_active;
      end
      col_d = (half_dup & tx_active & rx_active) | hb_on;
   end

   // carrier sense register
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         crs_q <= 1'b0;
      end else begin
         crs_q <= crs_d;
      end
   end

   // collision register
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         col_q <= 1'b0;
      end else begin
         col_q <= col_d;
      end
   end

   assign crs = crs_q;
   assign col = col_q;

   ////////////////////////////////////////////////////////////////////////////
   // heartbeat after each 10 Mb/s half duplex transmission

   prs_hb_state_type hb_state_q;
   logic [HB_CNT_W-1:0] hb_cnt_q;
   logic tx_prev_q;
   logic hb_trig;

   assign hb_trig = tx_prev_q & ~tx_active & half_dup & ~mode.speed_100
                    & mode.heartbeat_en;
   assign hb_on = (hb_state_q == HB_PULSE);

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_prev_q <= 1'b0;
      end else begin
         tx_prev_q <= tx_active;
      end
   end

   // pulse state, new triggers ignored while high
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hb_state_q <= HB_IDLE;
      end else begin
         unique case (hb_state_q)
            HB_IDLE: begin
               if (hb_trig) begin
                  hb_state_q <= HB_PULSE;
               end
            end
            HB_PULSE: begin
               if (hb_cnt_q == '0) begin
                  hb_state_q <= HB_IDLE;
               end
            end
         endcase
      end
   end

   // pulse length counter
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hb_cnt_q <= '0;
      end else if (hb_trig && !hb_on) begin
         hb_cnt_q <= HB_CNT_W'(HB_PULSE_CYCLES - 1);
      end else if (hb_on && hb_cnt_q != '0) begin
         hb_cnt_q <= hb_cnt_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive nibble launch

   prs_mii_rx_type rx_q;

   // nibble consumed at each falling edge only while rx_nib.valid is high
   assign rx_nib_take = rx_clk_fall & rx_nib.valid;

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_q.rx_dv <= 1'b0;
         rx_q.rx_er <= 1'b0;
         rx_q.rxd <= NIB_RESET;
      end else if (rx_clk_fall) begin
         rx_q.rx_dv <= rx_nib.valid;
         rx_q.rx_er <= rx_nib.valid & rx_nib.err & mode.speed_100;
         if (rx_nib.valid) begin
            rx_q.rxd <= rx_nib.data;
         end
      end
   end

   // held nibble while idle
   assign mii_rx = rx_q;

   ////////////////////////////////////////////////////////////////////////////
   // management data pin

   logic mdio_oe_q;

   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mdio_oe_q <= 1'b0;
      end else begin
         mdio_oe_q <= mgmt_pull_low;
      end
   end

   assign mdio_o = 1'b0;
   assign mdio_oe = mdio_oe_q;

endmodule : prs_mii_status

//--- testbench/prs_mii_status_checker.sv
/*
 prs_mii_status_checker: port assertions for prs_mii_status.
 assumes it is bound onto the top module.
*/
module prs_mii_status_checker (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire prs_pkg::prs_mode_type mode,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire prs_pkg::prs_nib_type rx_nib,
   input wire logic rx_nib_take,
   input wire logic crs,
   input wire logic col,
   input wire prs_pkg::prs_mii_rx_type mii_rx,
   input wire logic mgmt_pull_low,
   input wire logic mdio_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   import prs_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_CRS_HD: assert property (!mode.full_duplex && (rx_active || tx_active) |=> crs)
      else $error("crs low");
   AST_CRS_FD: assert property (mode.full_duplex && !rx_active |=> !crs)
      else $error("crs high");
   AST_COL: assert property (!mode.full_duplex && rx_active && tx_active |=> col)
      else $error("col low");
   AST_HB: assert property ($fell(tx_active) && mode == 3'b001 && !col
      |=> ##1 col [*8] ##92 col ##1 !col) else $error("bad heartbeat");
   AST_RXD: assert property (rx_nib_take |=> mii_rx.rxd == $past(rx_nib.data))
      else $error("bad rxd");
   AST_DV: assert property (rx_nib_take |=> mii_rx.rx_dv)
      else $error("dv low");
   AST_ER: assert property (rx_nib_take |=> mii_rx.rx_er ==
      ($past(rx_nib.err) && $past(mode.speed_100))) else $error("bad rx_er");
   AST_MDIO: assert property (mgmt_pull_low |=> mdio_oe)
      else $error("mdio not pulled");
   AST_TAKE: assert property (rx_nib_take |=> !rx_nib_take)
      else $error("take longer than one cycle");
   AST_IDLE: assert property (!mii_rx.rx_dv |-> !mii_rx.rx_er)
      else $error("rx_er outside frame");
endmodule : prs_mii_status_checker

bind prs_mii_status prs_mii_status_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .mode(mode), .rx_active(rx_active), .tx_active(tx_active), .rx_nib(rx_nib),
   .rx_nib_take(rx_nib_take), .crs(crs), .col(col), .mii_rx(mii_rx),
   .mgmt_pull_low(mgmt_pull_low), .mdio_oe(mdio_oe));

//--- testbench/prs_mac_model.sv
/*
 prs_mac_model: mac side, makes rx_clk and mdc, samples mii outputs.
 assumes mdio carries a pull-up.
*/
module prs_mac_model (
   output logic rx_clk,
   output logic mdc,
   input wire logic mac_pull,
   input wire logic mdio_oe,
   output logic mdio,
   input wire prs_pkg::prs_mii_rx_type mii_rx,
   output prs_pkg::prs_mii_rx_type cap
);
   timeunit 1ns;
   timeprecision 100ps;
   import prs_pkg::*;
   initial rx_clk = 0;
   initial mdc = 0;
   initial cap = '0;
   always #80 rx_clk = ~rx_clk;
   always #100 mdc = ~mdc;
   always @(posedge rx_clk) cap <= mii_rx;
   assign mdio = !(mdio_oe || mac_pull);
endmodule : prs_mac_model

//--- testbench/tb.sv
/*
 tb: self-checking bench for prs_mii_status.
 assumes prs_mac_model as far side.
*/
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import prs_pkg::*;
   logic ref_clk = 0, rstn = 0, rx_active = 0, tx_active = 0, mgmt_pull_low = 0, mac_pull = 0;
   logic rx_nib_take, rx_clk, crs, col, mdc, mdio_i, mdio_o, mdio_oe, mgmt_mdc, mgmt_mdio;
   prs_mode_type mode = '0;
   prs_nib_type rx_nib = '0;
   prs_mii_rx_type mii_rx, cap;
   int fails = 0, n_compared = 0, n;
   prs_mii_status u_dut (.ref_clk(ref_clk), .rstn(rstn), .mode(mode), .rx_active(rx_active),
      .tx_active(tx_active), .rx_nib(rx_nib), .rx_nib_take(rx_nib_take), .rx_clk(rx_clk),
      .crs(crs), .col(col), .mii_rx(mii_rx), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .mgmt_pull_low(mgmt_pull_low), .mgmt_mdc(mgmt_mdc),
      .mgmt_mdio(mgmt_mdio));
   prs_mac_model u_mac (.rx_clk(rx_clk), .mdc(mdc), .mac_pull(mac_pull), .mdio_oe(mdio_oe),
      .mdio(mdio_i), .mii_rx(mii_rx), .cap(cap));
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task close_out;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task wt(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : wt
   task send(input prs_nib_type nib, input logic [5:0] exp);
      int i;
      @(negedge ref_clk);
      rx_nib = nib;
      for (i = 0; i < 40 && rx_nib_take !== 1'b1; i++) @(negedge ref_clk);
      @(negedge ref_clk);
      @(posedge rx_clk);
      #1 chk(cap, exp);
      @(negedge ref_clk);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////
   task t_carrier;
      mode = 3'b010;
      tx_active = 1;
      wt(2);
      chk(crs, 1);
      mode = 3'b110;
      wt(2);
      chk(crs, 0);
      rx_active = 1;
      wt(2);
      chk({crs, col}, 2'b10);
      mode = 3'b010;
      wt(2);
      chk(col, 1);
      tx_active = 0;
      rx_active = 0;
      wt(4);
      $display("carrier done");
   endtask : t_carrier
   task t_hb;
      mode = 3'b001;
      tx_active = 1;
      wt(2);
      tx_active = 0;
      n = 0;
      repeat (120) begin
         @(negedge ref_clk);
         n += col;
      end
      chk(8'(n), 8'(HB_PULSE_CYCLES));
      mode = 3'b011;
      tx_active = 1;
      wt(2);
      tx_active = 0;
      n = 0;
      repeat (8) begin
         @(negedge ref_clk);
         n += col;
      end
      chk(8'(n), 8'h00);
      $display("heartbeat done");
   endtask : t_hb
   task t_rx;
      mode = 3'b010;
      send(6'b1_0_1010, 6'b1_0_1010);
      send(6'b1_1_0101, 6'b1_1_0101);
      mode = 3'b000;
      send(6'b1_1_0011, 6'b1_0_0011);
      send(6'b0_1_1111, 6'b0_0_0011);
      $display("receive done");
   endtask : t_rx
   task t_mdio;
      @(negedge ref_clk);
      mgmt_pull_low = 1;
      wt(4);
      chk({mdio_oe, mdio_o, mdio_i, mgmt_mdio}, 4'b1000);
      mgmt_pull_low = 0;
      mac_pull = 1;
      wt(4);
      chk({mdio_oe, mgmt_mdio}, 0);
      mac_pull = 0;
      wt(4);
      chk({mdio_oe, mgmt_mdio}, 1);
      @(posedge mdc);
      wt(3);
      chk(mgmt_mdc, 1);
      $display("mdio done");
   endtask : t_mdio
   initial begin
      wt(6);
      rstn = 1;
      wt(5);
      t_carrier;
      t_hb;
      t_rx;
      t_mdio;
      close_out;
   end
   initial begin
      #100000;
      fails++;
      close_out;
   end
endmodule : tb
